// ---- ddr_word_byte_placement.v ----
// Purpose: Places 16-bit words as A/B bytes on the 8-bit DDR lanes
// Assumes: Link clock far slower than clk_sys; command logic outside
// Notes: Link pins are sampled through two flops before any use
`timescale 1ns/1ps
`default_nettype none
`include "ddr_place_map.vh"

// How it works
// - Memory space: first byte of each word is byte A, second is byte B.
// - Memory words read back with bytes in the same A/B positions written.
// - No byte order imposed in memory space; array keeps host order.
// - Reads deliver two bytes per link clock, one whole word per cycle.
// - Register reads: upper half as byte A, strobe rising to falling.
// - Register reads: lower half as byte B, strobe falling to rising.
// - Register words travel big-endian: word bit 15 on lane 7 of A.
// - Writes with latency use the strobe as a per-byte write mask.
// - Zero-latency writes store whole words; device leaves strobe undriven.
// - Mask high keeps the array byte; mask low stores it.
// - Byte bit 7 sits on lane 7 down to bit 0 on lane 0.
module ddr_word_byte_placement (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Link pins
   input wire csN,
   input wire linkClk,
   input wire [`LANE_W-1:0] dqIn,
   output reg [`LANE_W-1:0] dqOut_r,
   output reg dqOe_r,
   input wire rwDataStrobeIn,
   output reg rwDataStrobeOut_r,
   output reg rwDataStrobeOe_r,
   // Transfer control from the command logic
   input wire dataPhase,
   input wire dataIsWrite,
   input wire writeMasked,
   // Write words toward the array
   output reg [`WORD_W-1:0] wrWord_r,
   output reg [1:0] wrByteEn_r,
   output reg wrValid_r,
   // Read words from the array
   input wire [`WORD_W-1:0] rdWord,
   input wire rdValid,
   output wire rdReady,
   // Status
   output reg rdStall_r
);

   localparam ST_IDLE = 2'h0;
   localparam ST_WRITE = 2'h1;
   localparam ST_READ = 2'h2;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg csMeta_r;
   reg csSync_r;
   reg ckMeta_r;
   reg ckSync_r;
   reg ckPrev_r;
   reg [`LANE_W-1:0] dqMeta_r;
   reg [`LANE_W-1:0] dqSync_r;
   reg rwdsMeta_r;
   reg rwdsSync_r;
   reg [`LANE_W-1:0] byteA_r;
   reg keepA_r;
   reg haveA_r;
   reg [`LANE_W-1:0] byteB_r;
   reg haveWord_r;
   wire ckRise;
   wire ckFall;
   wire active;
   wire [`WORD_W-1:0] bufWord;
   wire bufValid;
   wire bufPop;

   // Lane of byte A within a word; same placement in both spaces
   function [`LANE_W-1:0] laneA;
      input [`WORD_W-1:0] w;
      begin
         laneA = w[`BYTE_A_HI:`BYTE_A_LO];
      end
   endfunction

   // Lane of byte B within a word
   function [`LANE_W-1:0] laneB;
      input [`WORD_W-1:0] w;
      begin
         laneB = w[`BYTE_B_HI:`BYTE_B_LO];
      end
   endfunction

   // Two-flop synchronisers on every link pin
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         csMeta_r <= 1'b1;
         csSync_r <= 1'b1;
         ckMeta_r <= 1'b0;
         ckSync_r <= 1'b0;
         ckPrev_r <= 1'b0;
         dqMeta_r <= `RST_LANE;
         dqSync_r <= `RST_LANE;
         rwdsMeta_r <= 1'b0;
         rwdsSync_r <= 1'b0;
      end
      else
      begin
         csMeta_r <= csN;
         csSync_r <= csMeta_r;
         ckMeta_r <= linkClk;
         ckSync_r <= ckMeta_r;
         ckPrev_r <= ckSync_r;
         dqMeta_r <= dqIn;
         dqSync_r <= dqMeta_r;
         rwdsMeta_r <= rwDataStrobeIn;
         rwdsSync_r <= rwdsMeta_r;
      end
   end

   // Link clock edges seen on clk_sys
   assign ckRise = ckSync_r && !ckPrev_r;
   assign ckFall = !ckSync_r && ckPrev_r;
   assign active = !csSync_r && dataPhase;

   // Transfer phase selection
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (active && dataIsWrite)
            begin
               state_nxt = ST_WRITE;
            end
            else if (active)
            begin
               state_nxt = ST_READ;
            end
         end
         ST_WRITE:
         begin
            if (!active)
            begin
               state_nxt = ST_IDLE;
            end
         end
         ST_READ:
         begin
            if (!active)
            begin
               state_nxt = ST_IDLE;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= ST_IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Write capture: A on rising edge, B on falling edge
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         byteA_r <= `RST_LANE;
         keepA_r <= 1'b0;
         haveA_r <= 1'b0;
         wrWord_r <= `RST_WORD;
         wrByteEn_r <= `RST_MASK;
         wrValid_r <= 1'b0;
      end
      else
      begin
         wrValid_r <= 1'b0;
         if (state_r != ST_WRITE)
         begin
            haveA_r <= 1'b0;
         end
         else if (ckRise)
         begin
            byteA_r <= dqSync_r;
            keepA_r <= writeMasked && rwdsSync_r;
            haveA_r <= 1'b1;
         end
         else if (ckFall && haveA_r)
         begin
            wrWord_r <= {byteA_r, dqSync_r};
            if (writeMasked)
            begin
               wrByteEn_r <= {!keepA_r, !rwdsSync_r};
            end
            else
            begin
               wrByteEn_r <= `ALL_BYTES;
            end
            wrValid_r <= 1'b1;
            haveA_r <= 1'b0;
         end
      end
   end

   // Take one word per link cycle at its rising edge
   assign bufPop = (state_r == ST_READ) && ckRise;

   // Read drive: A with strobe high, B with strobe low, edge aligned
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         dqOut_r <= `RST_LANE;
         dqOe_r <= 1'b0;
         rwDataStrobeOut_r <= 1'b0;
         rwDataStrobeOe_r <= 1'b0;
         byteB_r <= `RST_LANE;
         haveWord_r <= 1'b0;
         rdStall_r <= 1'b0;
      end
      else if (state_r != ST_READ)
      begin
         // Strobe left undriven outside reads, zero-latency writes too
         dqOe_r <= 1'b0;
         rwDataStrobeOe_r <= 1'b0;
         rwDataStrobeOut_r <= 1'b0;
         haveWord_r <= 1'b0;
         rdStall_r <= 1'b0;
      end
      else
      begin
         dqOe_r <= 1'b1;
         rwDataStrobeOe_r <= 1'b1;
         if (ckRise && bufValid)
         begin
            dqOut_r <= laneA(bufWord);
            byteB_r <= laneB(bufWord);
            rwDataStrobeOut_r <= 1'b1;
            haveWord_r <= 1'b1;
            rdStall_r <= 1'b0;
         end
         else if (ckRise)
         begin
            // No word ready: strobe held low to stretch the gap
            rwDataStrobeOut_r <= 1'b0;
            haveWord_r <= 1'b0;
            rdStall_r <= 1'b1;
         end
         else if (ckFall && haveWord_r)
         begin
            dqOut_r <= byteB_r;
            rwDataStrobeOut_r <= 1'b0;
            haveWord_r <= 1'b0;
         end
      end
   end

   // Read words wait here; full buffer stalls the array side
   word_fifo #(
      .WIDTH(`WORD_W),
      .DEPTH(`RDBUF_DEPTH),
      .AW(`RDBUF_AW)
   ) u_rdbuf (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .inData(rdWord),
      .inValid(rdValid),
      .inReady(rdReady),
      .outData_r(bufWord),
      .outValid_r(bufValid),
      .outReady(bufPop)
   );

endmodule

`default_nettype wire

// ---- ddr_place_map.vh ----
// Purpose: Shared constants for the DDR word/byte placement block
// Assumes: Plain Verilog-2005 include, definitions only
// Notes: Widths, reset values and timing figures in one place
`ifndef DDR_PLACE_MAP_VH
`define DDR_PLACE_MAP_VH

// Lane and word widths
`define LANE_W 8
`define WORD_W 16
`define BYTE_A_HI 15
`define BYTE_A_LO 8
`define BYTE_B_HI 7
`define BYTE_B_LO 0

// Read buffer shape
`define RDBUF_DEPTH 16
`define RDBUF_AW 4

// Reset values of driven pins and outputs, plus the whole-word byte enable
`define RST_LANE 8'h00
`define RST_WORD 16'h0000
`define RST_MASK 2'h0
`define ALL_BYTES 2'h3

// Timing figures, in ns as printed for the bench
`define SYS_PERIOD_NS 25
`define LINK_PERIOD_NS 200
// System clocks per link half period, rounded down, at least one
`define LINK_HALF_CYC (((`LINK_PERIOD_NS / 2) / `SYS_PERIOD_NS) < 1 ? 1 : \
   ((`LINK_PERIOD_NS / 2) / `SYS_PERIOD_NS))

`endif

// ---- word_fifo.v ----
// Purpose: Word FIFO between the array side and the read lanes
// Assumes: Single clock, valid/ready on both sides
// Notes: Read data leaves from a register stage
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // Filling side
   input wire [WIDTH-1:0] inData,
   input wire inValid,
   output wire inReady,
   // Draining side
   output reg [WIDTH-1:0] outData_r,
   output reg outValid_r,
   input wire outReady
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_r;
   reg [AW-1:0] rdPtr_r;
   reg [AW:0] count_r;
   wire push;
   wire load;
   wire memEmpty;

   // Honest full and empty from the occupancy count
   assign memEmpty = (count_r == {(AW+1){1'b0}});
   assign inReady = (count_r != DEPTH[AW:0]);
   assign push = inValid && inReady;
   assign load = !memEmpty && (!outValid_r || outReady);

   // Storage array, written only on accepted pushes
   always @(posedge clk_sys)
   begin
      if (push)
      begin
         mem[wrPtr_r] <= inData;
      end
   end

   // Pointers, count and registered output stage
   always @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPtr_r <= {AW{1'b0}};
         rdPtr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         outData_r <= {WIDTH{1'b0}};
         outValid_r <= 1'b0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_r <= wrPtr_r + {{(AW-1){1'b0}}, 1'b1};
         end
         if (load)
         begin
            rdPtr_r <= rdPtr_r + {{(AW-1){1'b0}}, 1'b1};
            outData_r <= mem[rdPtr_r];
            outValid_r <= 1'b1;
         end
         else if (outReady)
         begin
            outValid_r <= 1'b0;
         end
         if (push && !load)
         begin
            count_r <= count_r + {{AW{1'b0}}, 1'b1};
         end
         else if (load && !push)
         begin
            count_r <= count_r - {{AW{1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

// ---- ddr_word_byte_placement_props.sv ----
// Purpose: Port assertions for the DDR word/byte placement block
// Assumes: Bench link period of 8 clk_sys cycles
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module ddr_word_byte_placement_props (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Link side
   input wire logic csN,
   input wire logic linkClk,
   input wire logic [7:0] dqOut_r,
   input wire logic dqOe_r,
   input wire logic rwDataStrobeOut_r,
   input wire logic rwDataStrobeOe_r,
   // Array side
   input wire logic writeMasked,
   input wire logic [1:0] wrByteEn_r,
   input wire logic wrValid_r,
   input wire logic rdStall_r
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // Deselected long enough to pass the synchronisers
   sequence idleLink;
      csN [*5];
   endsequence
   // One word pulse, then quiet for the next three clk_sys cycles
   sequence wordDone;
      wrValid_r ##1 !wrValid_r [*3];
   endsequence
   // Checks on write capture and read drive
   chk_wr_pulse: assert property (wrValid_r |-> wordDone)
      else $error("write pulse too long or too close");
   chk_zero_whole: assert property (wrValid_r && !writeMasked |-> wrByteEn_r == 2'h3)
      else $error("zero latency write not whole word");
   chk_wr_quiet: assert property (wrValid_r |-> !rwDataStrobeOe_r && !dqOe_r)
      else $error("device drives pins during write");
   chk_wr_on_fall: assert property (wrValid_r |-> !$past(linkClk, 2) && $past(linkClk, 6))
      else $error("word finished away from clock fall");
   chk_strobe_read: assert property ($rose(rwDataStrobeOut_r) |-> dqOe_r && rwDataStrobeOe_r)
      else $error("strobe rose outside a driven read");
   chk_idle_release: assert property (idleLink |-> !dqOe_r && !rwDataStrobeOe_r)
      else $error("pins still driven while deselected");
   chk_stall_low: assert property (rdStall_r |-> !rwDataStrobeOut_r)
      else $error("strobe high with no word");
   chk_lane_edge: assert property (dqOe_r && $changed(dqOut_r) |-> $changed(rwDataStrobeOut_r))
      else $error("lane change without strobe edge");
endmodule
bind ddr_word_byte_placement ddr_word_byte_placement_props chk_u (.clk_sys(clk_sys),
   .rstn(rstn), .csN(csN), .linkClk(linkClk), .dqOut_r(dqOut_r), .dqOe_r(dqOe_r),
   .rwDataStrobeOut_r(rwDataStrobeOut_r), .rwDataStrobeOe_r(rwDataStrobeOe_r),
   .writeMasked(writeMasked), .wrByteEn_r(wrByteEn_r), .wrValid_r(wrValid_r),
   .rdStall_r(rdStall_r));
`default_nettype wire

// ---- host_link_model.sv ----
// Purpose: Host controller side of the DDR link
// Assumes: 200 ns link period, clock parked low between frames
// Notes: Released pins show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
   // Pins toward the device
   output var logic csN,
   output var logic linkClk,
   output var logic [7:0] dqIn,
   output var logic rwDataStrobeIn,
   // Pins from the device
   input wire logic [7:0] dqOut,
   input wire logic rwDataStrobeOut
);
   // Idle link at time zero
   initial
   begin
      csN = 1'b1;
      linkClk = 1'b0;
      dqIn = 8'h5A;
      rwDataStrobeIn = 1'b0;
   end
   // Select with the clock parked low
   task automatic open_frame();
      csN = 1'b0;
      #150;
   endtask
   // One write word: A before the rise, B before the fall, centred data
   task automatic xfer(input logic [7:0] a, input logic [7:0] b, input logic ma,
      input logic mb, input logic drv);
      dqIn = a;
      rwDataStrobeIn = drv ? ma : ~rwDataStrobeIn;
      #50 linkClk = 1'b1;
      #50 dqIn = b;
      rwDataStrobeIn = drv ? mb : ~rwDataStrobeIn;
      #50 linkClk = 1'b0;
      #50;
   endtask
   // One read word: each byte is taken just before the next link edge,
   // since the device answers about three system clocks after an edge
   task automatic rd_word(output logic [17:0] seen);
      linkClk = 1'b1;
      #95 seen[17:9] = {rwDataStrobeOut, dqOut};
      #5 linkClk = 1'b0;
      #95 seen[8:0] = {rwDataStrobeOut, dqOut};
      #5;
   endtask
   // Deselect and release the lines
   task automatic close_frame();
      #100 csN = 1'b1;
      dqIn = ~dqIn;
      rwDataStrobeIn = ~rwDataStrobeIn;
      #200;
   endtask
endmodule
`default_nettype wire

// ---- ddr_word_byte_placement_bench.sv ----
// Purpose: Self-checking bench for the DDR word/byte placement block
// Assumes: Host model drives the link pins, bench the array side
// Notes: Write words are collected from the one-cycle valid pulse
`timescale 1ns/1ps
`default_nettype none
module ddr_word_byte_placement_bench;
   logic clk_sys, rstn, dataPhase, dataIsWrite, writeMasked, rdValid;
   logic [15:0] rdWord;
   wire csN, linkClk, strobeIn, dqOe_r, strobeOut, strobeOe, wrValid_r, rdReady, rdStall_r;
   wire [7:0] dqIn;
   wire [7:0] dqOut_r;
   wire [15:0] wrWord_r;
   wire [1:0] wrByteEn_r;
   int miscompares, comparisons;
   logic [17:0] wq[$];
   logic [17:0] seen;
   // Write table: {maskA, maskB, byteA, byteB}
   logic [17:0] wt[4] = '{18'h0_8001, 18'h2_1234, 18'h1_C35A, 18'h3_FF00};
   host_link_model host_u (.csN(csN), .linkClk(linkClk), .dqIn(dqIn),
      .rwDataStrobeIn(strobeIn), .dqOut(dqOut_r), .rwDataStrobeOut(strobeOut));
   ddr_word_byte_placement dut_u (.clk_sys(clk_sys), .rstn(rstn), .csN(csN),
      .linkClk(linkClk), .dqIn(dqIn), .dqOut_r(dqOut_r), .dqOe_r(dqOe_r),
      .rwDataStrobeIn(strobeIn), .rwDataStrobeOut_r(strobeOut), .rwDataStrobeOe_r(strobeOe),
      .dataPhase(dataPhase), .dataIsWrite(dataIsWrite), .writeMasked(writeMasked),
      .wrWord_r(wrWord_r), .wrByteEn_r(wrByteEn_r), .wrValid_r(wrValid_r), .rdWord(rdWord),
      .rdValid(rdValid), .rdReady(rdReady), .rdStall_r(rdStall_r));
   // 40 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Collect stored words
   always @(posedge clk_sys)
      if (wrValid_r === 1'b1)
         wq.push_back({wrByteEn_r, wrWord_r});
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   function automatic logic [15:0] w(input int n);
      return {8'(n * 37 + 1), 8'(200 - n * 11)};
   endfunction
   // Four words, masked or zero latency, covering all four mask patterns
   task automatic write_words(input logic m);
      int i;
      @(posedge clk_sys) #2;
      wq.delete();
      dataPhase = 1'b1;
      dataIsWrite = 1'b1;
      writeMasked = m;
      host_u.open_frame();
      for (i = 0; i < 4; i++)
         host_u.xfer(wt[i][15:8], wt[i][7:0], wt[i][17], wt[i][16], m);
      check({16'h0000, dqOe_r, strobeOe}, 18'h0);
      host_u.close_frame();
      @(posedge clk_sys) #2 dataPhase = 1'b0;
      check(18'(wq.size()), 18'd4);
      for (i = 0; i < 4 && wq.size() > 0; i++)
         check(wq.pop_front(), {m ? ~wt[i][17:16] : 2'b11, wt[i][15:0]});
   endtask
   // Fill the FIFO until refused, drain it on the link, then stall
   task automatic read_fifo();
      int n;
      logic [15:0] e;
      @(posedge clk_sys) #2;
      n = 0;
      rdValid = 1'b1;
      rdWord = w(0);
      while (rdReady === 1'b1 && n < 20)
      begin
         @(posedge clk_sys) #2;
         n++;
         rdWord = w(n);
      end
      rdValid = 1'b0;
      check(18'(n), 18'd17);
      dataPhase = 1'b1;
      dataIsWrite = 1'b0;
      writeMasked = 1'b0;
      host_u.open_frame();
      for (n = 0; n < 17; n++)
      begin
         e = w(n);
         host_u.rd_word(seen);
         check(seen, {1'b1, e[15:8], 1'b0, e[7:0]});
      end
      host_u.rd_word(seen);
      check({16'h0000, seen[17], rdStall_r}, 18'h1);
      check({16'h0000, dqOe_r, strobeOe}, 18'h3);
      host_u.close_frame();
      @(posedge clk_sys) #2 dataPhase = 1'b0;
      check({16'h0000, dqOe_r, strobeOe}, 18'h0);
   endtask
   // Hang guard
   initial
   begin
      #50000;
      miscompares++;
      summarize();
   end
   // Main sequence
   initial
   begin
      miscompares = 0;
      comparisons = 0;
      rstn = 1'b0;
      dataPhase = 1'b0;
      dataIsWrite = 1'b0;
      writeMasked = 1'b0;
      rdValid = 1'b0;
      rdWord = 16'h0000;
      repeat (3) @(posedge clk_sys);
      #2 rstn = 1'b1;
      write_words(1'b1);
      write_words(1'b0);
      read_fifo();
      summarize();
   end
endmodule
`default_nettype wire
